// File: design/wget_pkg.sv
// Functional notes
// - timer mode counts internal clock, matches compare, raises irq, clears, continues.
// - fast clock in slow mode compares only upper 7 of 18 compare bits.
// - event mode counts event pin falling edges only; software sets external clock, edge bit 0.
// - event mode match raises irq, clears counter, resumes on later event edges.
// - pulse-width mode counts falling edges of event-window AND internal clock.
// - pulse-width irq on window falling edge, or both edges when selected.
// - software reads count while stopped then clears; otherwise counting resumes from held value.
// - wrap from all ones sets overflow flag, held until clear bit.
// - pulse-width stop write while event high raises irq; software clears latch.
// - pulse-width both-edge start while event high raises irq.
// - gate state flag is invalid and held low in pulse-width mode.
// - window falling while internal clock high adds one final count.
// - frequency mode counts event edges while gate high; select 00 picks gate pin.
// - frequency mode irq on gate falling edge, or both edges when selected.
// - gate state flag is 1 during counting high period, 0 when stopped.
// - channel-six route bit 0 drives shared pin, 1 blocks it.
// - gate periods are (16 minus setting) times selected prescaler unit.
// - internal gate alternates high counting and low stopped periods.
// - first gate period after start may lag one prescaler unit.
// - low setting written during low period applies from next low period.
// - gate falling adds one count always with edge bit 1, else only if event high.
// - status bit 7 counting state, bit 6 overflow, other bits zero.
package wget_pkg;
  localparam int          CNT_W       = 18;
  localparam int          CMP_LO_BITS = 11;
  localparam int          DIV_W       = 24;
  localparam int          FS_LOG      = 9;
  localparam int          GATE_BASE   = 11;
  localparam logic [4:0]  GATE_SPAN   = 5'h10;
  localparam int          ST_CNT_BIT  = 7;
  localparam int          ST_OVF_BIT  = 6;
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [1:0]  START_STOP  = 2'h0;
  localparam logic [1:0]  START_RUN   = 2'h2;
  localparam logic [1:0]  GSRC_PIN    = 2'h0;
  localparam logic [1:0]  GSRC_INT    = 2'h1;
  localparam logic [1:0]  GSRC_CH6    = 2'h2;
  localparam logic [2:0]  CK_FC_SLOWEST = 3'h0;
  localparam logic [2:0]  CK_FC_13    = 3'h1;
  localparam logic [2:0]  CK_FC_11    = 3'h2;
  localparam logic [2:0]  CK_FC_7     = 3'h3;
  localparam logic [2:0]  CK_FC_3     = 3'h4;
  localparam logic [2:0]  CK_FC       = 3'h5;
  localparam logic [2:0]  CK_FS       = 3'h6;
  localparam logic [2:0]  CK_EXT      = 3'h7;
  typedef enum logic [3:0]
  {
    WGET_TIMER = 4'b0001,
    WGET_EVENT = 4'b0010,
    WGET_PWIDTH = 4'b0100,
    WGET_FREQ  = 4'b1000
  } wget_mode_e;
  typedef enum logic [2:0]
  {
    WGET_G_IDLE = 3'b001,
    WGET_G_HIGH = 3'b010,
    WGET_G_LOW  = 3'b100
  } wget_gate_e;
endpackage : wget_pkg

// File: design/wget_timer.sv
`timescale 1ns/1ps
module wget_timer #(
  parameter int CNT_W  = wget_pkg::CNT_W,
  parameter int FS_LOG = wget_pkg::FS_LOG
)
(
  // clock and reset
  input  wire logic               CORE_CLK_IN,
  input  wire logic               RESETN_IN,
  // control bits
  input  wire logic [3:0]         MODE_IN,
  input  wire logic [1:0]         START_CONTROL_IN,
  input  wire logic [2:0]         SOURCE_CLOCK_SELECT_IN,
  input  wire logic               DIVIDER_CLOCK_SELECT_IN,
  input  wire logic               SLOW_MODE_IN,
  input  wire logic               EDGE_MODE_SELECT_IN,
  input  wire logic               IRQ_EDGE_SELECT_IN,
  input  wire logic [1:0]         GATE_SOURCE_SELECT_IN,
  input  wire logic               COUNTER_CLEAR_BIT_IN,
  input  wire logic               CH6_OUTPUT_ROUTE_IN,
  input  wire logic [1:0]         GATE_PRESCALER_SELECT_IN,
  input  wire logic [3:0]         GATE_HIGH_TIME_IN,
  input  wire logic [3:0]         GATE_LOW_TIME_IN,
  input  wire logic [CNT_W-1:0]   COMPARE_CAPTURE_REG_IN,
  // channel-six waveform from on-chip timer
  input  wire logic               CH6_WAVE_IN,
  // pins
  input  wire logic               EVENT_INPUT_PIN_IN,
  input  wire logic               GATE_INPUT_PIN_IN,
  // results
  output logic                    TIMER_IRQ_OUT,
  output logic [CNT_W-1:0]        COUNT_OUT,
  output logic [7:0]              STATUS_REG_OUT,
  output logic                    SHARED_PORT_PIN_OUT,
  output logic                    SHARED_PORT_PIN_OE_N_OUT
);

  initial
  begin
    if (CNT_W <= wget_pkg::CMP_LO_BITS || FS_LOG < 1 || FS_LOG + 15 > wget_pkg::DIV_W)
      $error("wget_timer: unsupported parameter values");
  end

  logic [wget_pkg::DIV_W-1:0] div;
  logic [2:0]        ev_sy;
  logic [2:0]        gp_sy;
  logic [1:0]        start_q;
  logic              src_q;
  logic              and_q;
  logic              gate_q;
  logic              unit_q;
  logic [CNT_W-1:0]  cnt;
  logic              ovf;
  wget_pkg::wget_gate_e gst;
  logic [4:0]        gcnt;
  logic              running;
  logic              src_lvl;
  logic              src_fall;
  logic              ev_now;
  logic              ev_fall;
  logic              ev_edge;
  logic              gate_lvl;
  logic              gate_rise;
  logic              gate_fall;
  logic              and_now;
  logic              unit_lvl;
  logic              unit_tick;
  logic              cmp_hit;
  logic              inc;
  logic              match_clr;
  logic              irq_evt;
  logic [CNT_W-1:0]  next_cnt;
  logic              is_tm;
  logic              is_ev;
  logic              is_pw;
  logic              is_fq;
  logic              slow_src;

  // free-running internal divider feeding all prescaled clocks
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      div <= '0;
    else
      div <= div + 1'b1;
  end

  // two-flop synchronisers plus a history stage for edge detection
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ev_sy <= 3'h0;
      gp_sy <= 3'h0;
    end
    else
    begin
      ev_sy <= {ev_sy[1:0], EVENT_INPUT_PIN_IN};
      gp_sy <= {gp_sy[1:0], GATE_INPUT_PIN_IN};
    end
  end

  assign is_tm    = MODE_IN == wget_pkg::WGET_TIMER;
  assign is_ev    = MODE_IN == wget_pkg::WGET_EVENT;
  assign is_pw    = MODE_IN == wget_pkg::WGET_PWIDTH;
  assign is_fq    = MODE_IN == wget_pkg::WGET_FREQ;
  assign running  = START_CONTROL_IN == wget_pkg::START_RUN;
  assign slow_src = SLOW_MODE_IN || DIVIDER_CLOCK_SELECT_IN;
  assign ev_now   = ev_sy[1];
  assign ev_fall  = ev_sy[2] && !ev_sy[1];
  assign ev_edge  = ev_sy[2] != ev_sy[1];

  // selected internal source clock as a level
  always_comb
  begin
    case (SOURCE_CLOCK_SELECT_IN)
      wget_pkg::CK_FC_SLOWEST: src_lvl = slow_src ? div[FS_LOG+14] : div[22];
      wget_pkg::CK_FC_13:      src_lvl = slow_src ? div[FS_LOG+4] : div[12];
      wget_pkg::CK_FC_11:      src_lvl = slow_src ? div[FS_LOG+2] : div[10];
      wget_pkg::CK_FC_7:       src_lvl = div[6];
      wget_pkg::CK_FC_3:       src_lvl = div[2];
      wget_pkg::CK_FS:         src_lvl = div[FS_LOG-1];
      default:                 src_lvl = 1'b1;
    endcase
  end

  // full-rate clock ticks every cycle, others on their falling level
  assign src_fall = (SOURCE_CLOCK_SELECT_IN == wget_pkg::CK_FC) ? 1'b1 : (src_q && !src_lvl);

  // gate prescaler unit: 2^12..2^14 fast clocks or 2^4..2^6 slow clocks
  always_comb
  begin
    case (GATE_PRESCALER_SELECT_IN)
      2'h1:    unit_lvl = slow_src ? div[FS_LOG+4] : div[wget_pkg::GATE_BASE+1];
      2'h2:    unit_lvl = slow_src ? div[FS_LOG+5] : div[wget_pkg::GATE_BASE+2];
      default: unit_lvl = slow_src ? div[FS_LOG+3] : div[wget_pkg::GATE_BASE];
    endcase
  end
  assign unit_tick = unit_q && !unit_lvl;

  // history of start control, source level, window AND, gate and unit
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      start_q <= wget_pkg::START_STOP;
      src_q   <= 1'b0;
      and_q   <= 1'b0;
      gate_q  <= 1'b0;
      unit_q  <= 1'b0;
    end
    else
    begin
      start_q <= START_CONTROL_IN;
      src_q   <= src_lvl;
      and_q   <= and_now;
      gate_q  <= gate_lvl;
      unit_q  <= unit_lvl;
    end
  end

  // internal window gate: high then low, each (16 - setting) units
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      gst  <= wget_pkg::WGET_G_IDLE;
      gcnt <= '0;
    end
    else if (!running || !is_fq)
    begin
      gst  <= wget_pkg::WGET_G_IDLE;
      gcnt <= '0;
    end
    else if (unit_tick)
    begin
      case (gst)
        wget_pkg::WGET_G_IDLE:
        begin
          gst  <= wget_pkg::WGET_G_HIGH;
          gcnt <= wget_pkg::GATE_SPAN - {1'b0, GATE_HIGH_TIME_IN} - 5'h1;
        end
        wget_pkg::WGET_G_HIGH:
        begin
          if (gcnt == '0)
          begin
            gst  <= wget_pkg::WGET_G_LOW;
            gcnt <= wget_pkg::GATE_SPAN - {1'b0, GATE_LOW_TIME_IN} - 5'h1;
          end
          else
            gcnt <= gcnt - 5'h1;
        end
        wget_pkg::WGET_G_LOW:
        begin
          if (gcnt == '0)
          begin
            gst  <= wget_pkg::WGET_G_HIGH;
            gcnt <= wget_pkg::GATE_SPAN - {1'b0, GATE_HIGH_TIME_IN} - 5'h1;
          end
          else
            gcnt <= gcnt - 5'h1;
        end
        default:
        begin
          gst  <= wget_pkg::WGET_G_IDLE;
          gcnt <= '0;
        end
      endcase
    end
  end

  // window gate source for frequency mode
  always_comb
  begin
    case (GATE_SOURCE_SELECT_IN)
      wget_pkg::GSRC_PIN: gate_lvl = gp_sy[1];
      wget_pkg::GSRC_INT: gate_lvl = gst == wget_pkg::WGET_G_HIGH;
      wget_pkg::GSRC_CH6: gate_lvl = CH6_WAVE_IN;
      default:            gate_lvl = 1'b0;
    endcase
  end
  assign gate_rise = running && !gate_q && gate_lvl;
  assign gate_fall = running && gate_q && !gate_lvl;

  // event pin acts as window in pulse-width mode
  assign and_now = ev_now && src_lvl;

  // compare, upper bits only for full-rate clock in slow mode
  always_comb
  begin
    if (SLOW_MODE_IN && SOURCE_CLOCK_SELECT_IN == wget_pkg::CK_FC)
      cmp_hit = cnt[CNT_W-1:wget_pkg::CMP_LO_BITS] ==
                COMPARE_CAPTURE_REG_IN[CNT_W-1:wget_pkg::CMP_LO_BITS];
    else
      cmp_hit = cnt == COMPARE_CAPTURE_REG_IN;
  end

  // count enable per mode
  always_comb
  begin
    inc = 1'b0;
    if (running)
    begin
      if (is_tm)
        inc = src_fall;
      else if (is_ev)
        inc = ev_fall;
      else if (is_pw)
        inc = (SOURCE_CLOCK_SELECT_IN == wget_pkg::CK_FC) ? ev_sy[2] : (and_q && !and_now);
      else if (is_fq)
        inc = (gate_lvl && (EDGE_MODE_SELECT_IN ? ev_edge : ev_fall))
           || (gate_fall && (EDGE_MODE_SELECT_IN || ev_now));
    end
  end

  assign match_clr = running && (is_tm || is_ev) && cmp_hit;

  // interrupt events
  always_comb
  begin
    irq_evt = match_clr;
    if (is_pw)
    begin
      if (running && start_q == wget_pkg::START_RUN && ev_sy[2] != ev_now)
        irq_evt = !ev_now || IRQ_EDGE_SELECT_IN;
      if (start_q == wget_pkg::START_RUN && !running && ev_now)
        irq_evt = 1'b1;
      if (start_q != wget_pkg::START_RUN && running && ev_now && IRQ_EDGE_SELECT_IN)
        irq_evt = 1'b1;
    end
    else if (is_fq)
      irq_evt = gate_fall || (gate_rise && IRQ_EDGE_SELECT_IN);
  end

  // next counter value: clear bit, match clear, or increment
  always_comb
  begin
    next_cnt = cnt;
    if (COUNTER_CLEAR_BIT_IN)
      next_cnt = '0;
    else if (match_clr)
      next_cnt = '0;
    else if (inc)
      next_cnt = cnt + 1'b1;
  end

  // 18-bit up-counter holds value while stopped
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  // overflow flag: a same-cycle clear bit or match clear wins over the wrap
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      ovf <= 1'b0;
    else if (inc && !match_clr && !COUNTER_CLEAR_BIT_IN && &cnt)
      ovf <= 1'b1;
    else if (COUNTER_CLEAR_BIT_IN)
      ovf <= 1'b0;
  end

  // registered outputs
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      TIMER_IRQ_OUT            <= 1'b0;
      COUNT_OUT                <= '0;
      STATUS_REG_OUT           <= wget_pkg::STATUS_RST;
      SHARED_PORT_PIN_OUT      <= 1'b0;
      SHARED_PORT_PIN_OE_N_OUT <= 1'b1;
    end
    else
    begin
      TIMER_IRQ_OUT  <= irq_evt;
      COUNT_OUT      <= next_cnt;
      STATUS_REG_OUT <= wget_pkg::STATUS_RST;
      STATUS_REG_OUT[wget_pkg::ST_CNT_BIT] <= running && is_fq && gate_lvl;
      STATUS_REG_OUT[wget_pkg::ST_OVF_BIT] <= ovf;
      SHARED_PORT_PIN_OUT      <= CH6_WAVE_IN;
      SHARED_PORT_PIN_OE_N_OUT <= CH6_OUTPUT_ROUTE_IN;
    end
  end

  // checks
  sequence s_match;
    running && (is_tm || is_ev) && cmp_hit && !COUNTER_CLEAR_BIT_IN;
  endsequence

  sequence s_irq_cleared;
    TIMER_IRQ_OUT && COUNT_OUT == '0;
  endsequence

  property p_match_irq;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    s_match |=> s_irq_cleared;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match without irq and clear");

  property p_ev_count;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    running && is_ev && ev_fall && !cmp_hit && !COUNTER_CLEAR_BIT_IN |=> COUNT_OUT == $past(cnt) + 1'b1;
  endproperty
  a_ev_count: assert property (p_ev_count) else $error("event edge not counted");

  property p_ev_hold;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    is_ev && !ev_fall && !match_clr && !COUNTER_CLEAR_BIT_IN |=> cnt == $past(cnt);
  endproperty
  a_ev_hold: assert property (p_ev_hold) else $error("event counter moved without edge");

  property p_ovf_set;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    inc && &cnt && !match_clr && !COUNTER_CLEAR_BIT_IN |=> cnt == '0 ##1 STATUS_REG_OUT[wget_pkg::ST_OVF_BIT];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("wrap did not raise overflow");

  property p_ovf_clr;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    COUNTER_CLEAR_BIT_IN && !inc |=> !ovf && cnt == '0;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("clear bit left overflow or count");

  property p_pw_flag;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    is_pw |=> !STATUS_REG_OUT[wget_pkg::ST_CNT_BIT];
  endproperty
  a_pw_flag: assert property (p_pw_flag) else $error("gate flag set in pulse-width mode");

  property p_fq_irq;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    is_fq && gate_fall |=> TIMER_IRQ_OUT;
  endproperty
  a_fq_irq: assert property (p_fq_irq) else $error("gate fall without irq");

  property p_gate_flag;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    !running |=> !STATUS_REG_OUT[wget_pkg::ST_CNT_BIT];
  endproperty
  a_gate_flag: assert property (p_gate_flag) else $error("gate flag set while stopped");

  property p_route;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    $stable(CH6_OUTPUT_ROUTE_IN) |=> SHARED_PORT_PIN_OE_N_OUT == $past(CH6_OUTPUT_ROUTE_IN);
  endproperty
  a_route: assert property (p_route) else $error("shared pin routing wrong");

  property p_gate_low_stops;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    is_fq && !gate_lvl && !gate_fall && !COUNTER_CLEAR_BIT_IN |=> cnt == $past(cnt);
  endproperty
  a_gate_low_stops: assert property (p_gate_low_stops) else $error("counted while gate low");

  property p_fall_plus_one;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    is_fq && gate_fall && EDGE_MODE_SELECT_IN && !COUNTER_CLEAR_BIT_IN |=> cnt == $past(cnt) + 1'b1;
  endproperty
  a_fall_plus_one: assert property (p_fall_plus_one) else $error("gate fall missed final count");

endmodule : wget_timer

// File: sim/wget_pulse_src.sv
`timescale 1ns/1ps
module wget_pulse_src
(
  // clock
  input  wire logic       clk_in,
  // command from the bench
  input  wire logic       go_in,
  input  wire logic [7:0] pulses_in,
  input  wire logic [7:0] width_in,
  input  wire logic       idle_lvl_in,
  // pin and state
  output logic            pin_out,
  output logic            busy_out
);
  int w;
  // pulse train on the event pin, changed only at falling clock edges
  initial
  begin
    pin_out  = 1'b0;
    busy_out = 1'b0;
    forever
    begin
      @(posedge clk_in);
      if (go_in)
      begin
        busy_out = 1'b1;
        // never shorter than four cycles per level
        w = (width_in < 8'h04) ? 4 : int'(width_in);
        for (int i = 0; i < int'(pulses_in); i++)
        begin
          @(negedge clk_in) pin_out = 1'b1;
          repeat (w) @(negedge clk_in);
          pin_out = 1'b0;
          repeat (w - 1) @(negedge clk_in);
        end
        @(posedge clk_in) busy_out = 1'b0;
      end
      @(negedge clk_in) pin_out = idle_lvl_in;
    end
  end
endmodule : wget_pulse_src

// File: sim/tb_window_gated_event_timer.sv
`timescale 1ns/1ps
module tb_window_gated_event_timer;
  logic        CORE_CLK_IN, RESETN_IN, SLOW_MODE_IN, EDGE_MODE_SELECT_IN, IRQ_EDGE_SELECT_IN;
  logic        COUNTER_CLEAR_BIT_IN, CH6_OUTPUT_ROUTE_IN, CH6_WAVE_IN, GATE_INPUT_PIN_IN;
  logic        EVENT_INPUT_PIN_IN, TIMER_IRQ_OUT, SHARED_PORT_PIN_OUT, SHARED_PORT_PIN_OE_N_OUT;
  logic [3:0]  MODE_IN, GATE_HIGH_TIME_IN, GATE_LOW_TIME_IN;
  logic [1:0]  START_CONTROL_IN, GATE_SOURCE_SELECT_IN;
  logic [2:0]  SOURCE_CLOCK_SELECT_IN;
  logic [17:0] COMPARE_CAPTURE_REG_IN, COUNT_OUT;
  logic [7:0]  STATUS_REG_OUT, npulse, width;
  logic        go, idle_lvl, busy;
  logic [1:0]  gps = 2'h0;
  logic [31:0] seed = 32'h0000_ce01;
  int          failures = 0;
  int          checked = 0;
  int          irq_n = 0;
  int          exp_cnt;
  time         irq_t = 0;
  time         irq_prev = 0;

  // design under test
  wget_timer DUT (.CORE_CLK_IN, .RESETN_IN, .MODE_IN, .START_CONTROL_IN, .SOURCE_CLOCK_SELECT_IN,
    .DIVIDER_CLOCK_SELECT_IN(1'b0), .SLOW_MODE_IN, .EDGE_MODE_SELECT_IN, .IRQ_EDGE_SELECT_IN,
    .GATE_SOURCE_SELECT_IN, .COUNTER_CLEAR_BIT_IN, .CH6_OUTPUT_ROUTE_IN, .GATE_PRESCALER_SELECT_IN(gps),
    .GATE_HIGH_TIME_IN, .GATE_LOW_TIME_IN, .COMPARE_CAPTURE_REG_IN, .CH6_WAVE_IN, .EVENT_INPUT_PIN_IN,
    .GATE_INPUT_PIN_IN, .TIMER_IRQ_OUT, .COUNT_OUT, .STATUS_REG_OUT, .SHARED_PORT_PIN_OUT,
    .SHARED_PORT_PIN_OE_N_OUT);

  // external pulse source on the event pin
  wget_pulse_src src (.clk_in(CORE_CLK_IN), .go_in(go), .pulses_in(npulse), .width_in(width),
    .idle_lvl_in(idle_lvl), .pin_out(EVENT_INPUT_PIN_IN), .busy_out(busy));

  // clock generator
  initial
  begin
    CORE_CLK_IN = 1'b0;
    forever #20 CORE_CLK_IN = ~CORE_CLK_IN;
  end

  // interrupt pulses counted and time-stamped where they are settled
  always @(negedge CORE_CLK_IN)
  begin
    if (TIMER_IRQ_OUT === 1'b1)
    begin
      irq_n++;
      irq_prev = irq_t;
      irq_t = $time;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic results();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic fail(input string msg);
    failures++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk_cnt(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp)
      fail($sformatf("count %0h expected %0h", got, exp));
  endtask : chk_cnt

  task automatic chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp)
      fail($sformatf("flag %b expected %b", got, exp));
  endtask : chk_flag

  task automatic chk_num(input longint got, input longint exp);
    checked++;
    if (got != exp)
      fail($sformatf("number %0d expected %0d", got, exp));
  endtask : chk_num

  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK_IN);
  endtask : cyc

  task automatic clear();
    COUNTER_CLEAR_BIT_IN = 1'b1;
    cyc(2);
    COUNTER_CLEAR_BIT_IN = 1'b0;
  endtask : clear

  // pulse train of n pulses, each level w cycles, then settle
  task automatic send(input int n, input int w);
    int k;
    npulse = n[7:0];
    width = w[7:0];
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 4000)
    begin
      cyc(1);
      k++;
    end
    if (k >= 4000)
      fail("pulse source stuck");
    cyc(6);
  endtask : send

  // interval between two interrupts in timer mode
  task automatic tmr(input logic sl, input logic [17:0] c, input int per);
    int n0;
    int k;
    START_CONTROL_IN = wget_pkg::START_STOP;
    SLOW_MODE_IN = sl;
    COMPARE_CAPTURE_REG_IN = c;
    clear();
    START_CONTROL_IN = wget_pkg::START_RUN;
    n0 = irq_n;
    k = 0;
    while (irq_n < n0 + 3 && k < 8000)
    begin
      cyc(1);
      k++;
    end
    if (k >= 8000)
      fail("timer interrupts missing");
    chk_num((irq_t - irq_prev) / 40, per);
  endtask : tmr

  // one gate window on the gate pin or channel-six waveform with k event pulses inside
  task automatic frq(input logic s, input logic ie, input int k, input logic c);
    int n0;
    EDGE_MODE_SELECT_IN = s;
    IRQ_EDGE_SELECT_IN = ie;
    if (c)
    begin
      clear();
      exp_cnt = 0;
    end
    n0 = irq_n;
    {CH6_WAVE_IN, GATE_INPUT_PIN_IN} = (GATE_SOURCE_SELECT_IN == wget_pkg::GSRC_CH6) ? 2'b10 : 2'b01;
    cyc(8);
    chk_flag(STATUS_REG_OUT[7], 1'b1);
    send(k, 5);
    {CH6_WAVE_IN, GATE_INPUT_PIN_IN} = 2'b00;
    cyc(10);
    exp_cnt += s ? 2 * k + 1 : k;
    chk_cnt(COUNT_OUT, 18'(exp_cnt));
    chk_flag(STATUS_REG_OUT[7], 1'b0);
    chk_num(irq_n - n0, ie ? 2 : 1);
  endtask : frq

  // one window pulse of w cycles in pulse-width mode
  task automatic pw(input logic ie, input int w);
    int n0;
    IRQ_EDGE_SELECT_IN = ie;
    clear();
    n0 = irq_n;
    send(1, w);
    chk_cnt(COUNT_OUT, 18'(w));
    chk_num(irq_n - n0, ie ? 2 : 1);
    chk_flag(STATUS_REG_OUT[7], 1'b0);
  endtask : pw

  // length of the current run of the gate state flag at level v
  task automatic run_len(input logic v, output int n);
    n = 0;
    while (STATUS_REG_OUT[7] === v && n < 20000)
    begin
      cyc(1);
      n++;
    end
  endtask : run_len

  // main sequence
  initial
  begin
    int n0;
    int n;
    RESETN_IN = 1'b0;
    MODE_IN = wget_pkg::WGET_TIMER;
    START_CONTROL_IN = wget_pkg::START_STOP;
    SOURCE_CLOCK_SELECT_IN = wget_pkg::CK_FC;
    SLOW_MODE_IN = 1'b0;
    EDGE_MODE_SELECT_IN = 1'b0;
    IRQ_EDGE_SELECT_IN = 1'b0;
    GATE_SOURCE_SELECT_IN = wget_pkg::GSRC_PIN;
    COUNTER_CLEAR_BIT_IN = 1'b0;
    CH6_OUTPUT_ROUTE_IN = 1'b0;
    GATE_HIGH_TIME_IN = 4'hf;
    GATE_LOW_TIME_IN = 4'he;
    COMPARE_CAPTURE_REG_IN = 18'h0_0000;
    CH6_WAVE_IN = 1'b0;
    GATE_INPUT_PIN_IN = 1'b0;
    go = 1'b0;
    npulse = 8'h00;
    width = 8'h04;
    idle_lvl = 1'b0;
    cyc(4);
    chk_cnt(COUNT_OUT, 18'h0_0000);
    chk_cnt(18'(STATUS_REG_OUT), 18'(wget_pkg::STATUS_RST));
    cyc(4);
    RESETN_IN = 1'b1;
    cyc(2);
    // timer mode: random compare at full rate, then upper-bit compare in slow mode
    seed = lfsr(seed);
    tmr(1'b0, 18'h0_0003 + 18'(seed[3:0]), int'(seed[3:0]) + 4);
    tmr(1'b1, 18'h0_0a55, 2049);
    // event counter mode with random compare
    START_CONTROL_IN = wget_pkg::START_STOP;
    SLOW_MODE_IN = 1'b0;
    MODE_IN = wget_pkg::WGET_EVENT;
    SOURCE_CLOCK_SELECT_IN = wget_pkg::CK_EXT;
    seed = lfsr(seed);
    COMPARE_CAPTURE_REG_IN = 18'h0_0002 + 18'(seed[1:0]);
    clear();
    START_CONTROL_IN = wget_pkg::START_RUN;
    exp_cnt = 0;
    n0 = irq_n;
    n = 0;
    repeat (8)
    begin
      seed = lfsr(seed);
      send(1, 4 + int'(seed[2:0]));
      exp_cnt++;
      if (exp_cnt == int'(COMPARE_CAPTURE_REG_IN))
      begin
        exp_cnt = 0;
        n++;
      end
      chk_cnt(COUNT_OUT, 18'(exp_cnt));
    end
    chk_num(irq_n - n0, n);
    // frequency mode on the gate pin, with and without clearing in between
    START_CONTROL_IN = wget_pkg::START_STOP;
    cyc(1);
    MODE_IN = wget_pkg::WGET_FREQ;
    START_CONTROL_IN = wget_pkg::START_RUN;
    frq(1'b0, 1'b0, 3, 1'b1);
    frq(1'b0, 1'b1, 2, 1'b0);
    frq(1'b1, 1'b0, 3, 1'b1);
    frq(1'b1, 1'b1, 0, 1'b1);
    // channel-six waveform as the window gate
    GATE_SOURCE_SELECT_IN = wget_pkg::GSRC_CH6;
    frq(1'b0, 1'b1, 2, 1'b1);
    GATE_SOURCE_SELECT_IN = wget_pkg::GSRC_PIN;
    // pulse-width mode at full rate
    START_CONTROL_IN = wget_pkg::START_STOP;
    cyc(1);
    MODE_IN = wget_pkg::WGET_PWIDTH;
    SOURCE_CLOCK_SELECT_IN = wget_pkg::CK_FC;
    EDGE_MODE_SELECT_IN = 1'b0;
    START_CONTROL_IN = wget_pkg::START_RUN;
    pw(1'b0, 6);
    pw(1'b1, 9);
    // start and stop while the window is high
    START_CONTROL_IN = wget_pkg::START_STOP;
    idle_lvl = 1'b1;
    cyc(8);
    n0 = irq_n;
    START_CONTROL_IN = wget_pkg::START_RUN;
    cyc(6);
    chk_num(irq_n - n0, 1);
    START_CONTROL_IN = wget_pkg::START_STOP;
    cyc(6);
    chk_num(irq_n - n0, 2);
    idle_lvl = 1'b0;
    cyc(8);
    // internal gate: high 1 unit, low 2 units of 4096 cycles
    MODE_IN = wget_pkg::WGET_FREQ;
    SOURCE_CLOCK_SELECT_IN = wget_pkg::CK_EXT;
    GATE_SOURCE_SELECT_IN = wget_pkg::GSRC_INT;
    START_CONTROL_IN = wget_pkg::START_RUN;
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk_num(n, 4096);
    run_len(1'b0, n);
    chk_num(n, 8192);
    // second prescaler code doubles the unit to 8192 cycles
    START_CONTROL_IN = wget_pkg::START_STOP;
    gps = 2'h1;
    cyc(2);
    START_CONTROL_IN = wget_pkg::START_RUN;
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk_num(n, 8192);
    // channel-six routing to the shared pin
    for (int r = 0; r < 2; r++)
    begin
      CH6_OUTPUT_ROUTE_IN = r[0];
      repeat (4)
      begin
        seed = lfsr(seed);
        CH6_WAVE_IN = seed[0];
        cyc(2);
        chk_flag(SHARED_PORT_PIN_OE_N_OUT, CH6_OUTPUT_ROUTE_IN);
        if (r == 0)
          chk_flag(SHARED_PORT_PIN_OUT, CH6_WAVE_IN);
      end
    end
    results();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #3200000;
    failures++;
    results();
  end
endmodule : tb_window_gated_event_timer
